/* design/tsr_pkg.sv */
// Constants and types for the thermometer user register bank
package tsr_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_KHZ = 25000;
  localparam real CONV_9BIT_MS = 93.75;
  localparam int CONV_9BIT_CYC = int'($floor(CONV_9BIT_MS * CLK_KHZ));
  localparam real EE_WRITE_TYP_MS = 4.0;
  localparam real EE_WRITE_MAX_MS = 10.0;
  localparam int EE_WRITE_TYP_CYC = int'($floor(EE_WRITE_TYP_MS * CLK_KHZ));
  localparam int EE_WRITE_MAX_CYC = int'($floor(EE_WRITE_MAX_MS * CLK_KHZ));
  localparam int CONV_CNT_W = 25;
  localparam int EE_CNT_W = 18;
  // ==========================================================
  // Reset and factory values
  localparam logic [15:0] TEMP_RESET = 16'hc400;
  localparam logic [15:0] TH_FACTORY = 16'h0f00;
  localparam logic [15:0] TL_FACTORY = 16'h0a00;
  localparam logic [1:0] CFG_NV_FACTORY = 2'h0;
  localparam logic [1:0] RES_RESET = 2'h3;
  // ==========================================================
  // Configuration bit positions
  localparam int CFG_DONE = 7;
  localparam int CFG_THF = 6;
  localparam int CFG_TLF = 5;
  localparam int CFG_NVB = 4;
  localparam int CFG_POL = 1;
  localparam int CFG_ONESHOT = 0;
  // ==========================================================
  // Bus address and command codes
  localparam logic [3:0] BUS_ADDR_PREFIX = 4'h9;
  localparam logic [7:0] CMD_START_CONV = 8'h10;
  localparam logic [7:0] CMD_STOP_CONV = 8'h11;
  localparam logic [7:0] CMD_READ_TEMP = 8'h20;
  localparam logic [7:0] CMD_ACCESS_UPPER = 8'h21;
  localparam logic [7:0] CMD_ACCESS_LOWER = 8'h22;
  localparam logic [7:0] CMD_ACCESS_CFG = 8'h23;
  // ==========================================================
  // Types
  typedef enum logic [2:0] {LK_IDLE, LK_ADDR, LK_CMD, LK_WDATA, LK_RDATA} tsr_link_t;
  typedef enum logic [1:0] {EE_UPPER, EE_LOWER, EE_CFG} tsr_ee_t;
  // Keeps the resolved upper bits for a resolution code
  function automatic logic [15:0] tsr_res_mask(input logic [1:0] res);
    tsr_res_mask = 16'hff80 | (16'h0070 & ~(16'h0070 >> res));
  endfunction
endpackage

/* design/tsr_regs.sv */
// Thermometer user register bank with two-wire slave port
// Contract
// R1: Conversion ends within resolution dependent maximum
// R2: Nonvolatile write finishes within ten milliseconds
// R3: Read-only temperature register, resets to minus sixty
// R4: Upper trip point nonvolatile, factory fifteen degrees
// R5: Lower trip point nonvolatile, factory ten degrees
// R6: Config low two bits nonvolatile, rest volatile
// R7: Config upper bits reset to 100011
// R8: Resolution bits select resolution, default twelve
// R9: Result left justified, unused low bits zero
// R10: Trip points masked to resolution on read
// R11: High/low flags sticky until written zero
// R12: Host waits write cycle between nonvolatile writes
`timescale 1ns/1ns
module tsr_regs
  import tsr_pkg::*;
#(
  parameter int CONV_9BIT_CYCLES = CONV_9BIT_CYC,
  parameter int EE_WRITE_CYCLES = EE_WRITE_TYP_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Two-wire bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [2:0] addr_pins,
  // Measurement and thermostat
  input wire logic [15:0] sensor_temp,
  output logic tout
);
  // ==========================================================
  // Input synchronisers
  logic [2:0] scl_q, sda_q;
  logic [2:0] addr_s1_q, addr_s2_q;
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
      addr_s1_q <= 3'h0;
      addr_s2_q <= 3'h0;
    end
    else
    begin
      scl_q <= {scl_q[1:0], scl_in};
      sda_q <= {sda_q[1:0], sda_in};
      addr_s1_q <= addr_pins;
      addr_s2_q <= addr_s1_q;
    end
  end
  logic scl_rise, scl_fall, bus_start, bus_stop, conv_fin, cfg_wr;
  assign scl_rise = scl_q[1] && !scl_q[2];
  assign scl_fall = !scl_q[1] && scl_q[2];
  assign bus_start = scl_q[1] && scl_q[2] && !sda_q[1] && sda_q[2];
  assign bus_stop = scl_q[1] && scl_q[2] && sda_q[1] && !sda_q[2];
  // ==========================================================
  // State
  tsr_link_t st_q, st_d;
  tsr_ee_t ee_tgt_q, ee_tgt_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, cmd_q, cmd_d, wbuf_q, wbuf_d;
  logic byte_q, byte_d, oe_q, oe_d;
  logic [15:0] temp_q, temp_d, th_q, th_d, tl_q, tl_d, ee_data_q, ee_data_d;
  logic [1:0] nv_cfg_q, nv_cfg_d, res_q, res_d;
  logic done_q, done_d, thf_q, thf_d, tlf_q, tlf_d, act_q, act_d;
  logic conv_on_q, conv_on_d, cont_q, cont_d, ee_busy_q, ee_busy_d;
  logic [CONV_CNT_W-1:0] conv_cnt_q, conv_cnt_d, conv_limit;
  logic [EE_CNT_W-1:0] ee_cnt_q, ee_cnt_d;
  logic [15:0] mask, rd_word, conv_val;
  logic [7:0] cfg_byte, rd_byte;
  assign mask = tsr_res_mask(res_q);
  assign cfg_byte = {done_q, thf_q, tlf_q, ee_busy_q, res_q, nv_cfg_q};
  // R8: resolution doubles time
  assign conv_limit = CONV_CNT_W'(CONV_9BIT_CYCLES) << res_q;
  // R9: left justified result
  assign conv_val = sensor_temp & mask;
  // R9 R10: masked readout
  assign rd_word = (cmd_q == CMD_READ_TEMP) ? (temp_q & mask) :
    (cmd_q == CMD_ACCESS_UPPER) ? (th_q & mask) :
    (cmd_q == CMD_ACCESS_LOWER) ? (tl_q & mask) : {cfg_byte, cfg_byte};
  assign rd_byte = byte_q ? rd_word[7:0] : rd_word[15:8];
  // ==========================================================
  // Next state
  always_comb
  begin
    st_d = st_q; bit_d = bit_q; sh_d = sh_q; cmd_d = cmd_q; wbuf_d = wbuf_q;
    byte_d = byte_q; oe_d = oe_q; ee_tgt_d = ee_tgt_q; ee_data_d = ee_data_q;
    temp_d = temp_q; th_d = th_q; tl_d = tl_q; nv_cfg_d = nv_cfg_q; res_d = res_q;
    done_d = done_q; thf_d = thf_q; tlf_d = tlf_q; act_d = act_q;
    conv_on_d = conv_on_q; cont_d = cont_q; conv_cnt_d = conv_cnt_q;
    ee_busy_d = ee_busy_q; ee_cnt_d = ee_cnt_q;
    conv_fin = 1'b0;
    cfg_wr = 1'b0;
    if (bus_start)
    begin
      st_d = LK_ADDR; bit_d = 4'h0; byte_d = 1'b0; oe_d = 1'b0;
    end
    else if (bus_stop)
    begin
      st_d = LK_IDLE; oe_d = 1'b0;
    end
    else if (st_q == LK_RDATA)
    begin
      if (scl_fall)
        oe_d = (bit_q < 4'h8) ? !rd_byte[3'(4'h7 - bit_q)] : 1'b0;
      if (scl_rise)
      begin
        bit_d = bit_q + 4'h1;
        if (bit_q == 4'h8)
        begin
          bit_d = 4'h0;
          byte_d = !byte_q;
          st_d = sda_q[1] ? LK_IDLE : st_q;
        end
      end
    end
    else if (st_q != LK_IDLE)
    begin
      if (scl_rise && bit_q < 4'h8)
      begin
        sh_d = {sh_q[6:0], sda_q[1]};
        bit_d = bit_q + 4'h1;
      end
      if (scl_fall && bit_q == 4'h8)
      begin
        bit_d = 4'h9;
        oe_d = (st_q != LK_ADDR) || (sh_q[7:1] == {BUS_ADDR_PREFIX, addr_s2_q});
        unique case (st_q)
          LK_ADDR:
            if (!oe_d)
              st_d = LK_IDLE;
          LK_CMD:
          begin
            cmd_d = sh_q;
            if (sh_q == CMD_START_CONV)
            begin
              conv_on_d = 1'b1; conv_cnt_d = '0; done_d = 1'b0;
              cont_d = !nv_cfg_q[CFG_ONESHOT];
            end
            if (sh_q == CMD_STOP_CONV)
            begin
              conv_on_d = 1'b0; cont_d = 1'b0;
            end
          end
          default:
          begin
            byte_d = !byte_q;
            if (cmd_q == CMD_ACCESS_CFG)
            begin
              cfg_wr = 1'b1;
              // R11: write zero clears flag
              thf_d = thf_q & sh_q[CFG_THF];
              tlf_d = tlf_q & sh_q[CFG_TLF];
              res_d = sh_q[3:2];
              // R6: low bits go nonvolatile
              if (!ee_busy_q)
              begin
                ee_busy_d = 1'b1; ee_cnt_d = '0; ee_tgt_d = EE_CFG;
                ee_data_d = {14'h0000, sh_q[1:0]};
              end
            end
            else if ((cmd_q == CMD_ACCESS_UPPER) || (cmd_q == CMD_ACCESS_LOWER))
            begin
              if (!byte_q)
                wbuf_d = sh_q;
              else if (!ee_busy_q)
              begin
                ee_busy_d = 1'b1; ee_cnt_d = '0; ee_data_d = {wbuf_q, sh_q};
                ee_tgt_d = (cmd_q == CMD_ACCESS_UPPER) ? EE_UPPER : EE_LOWER;
              end
            end
          end
        endcase
      end
      else if (scl_fall && bit_q == 4'h9)
      begin
        bit_d = 4'h0;
        oe_d = 1'b0;
        if (st_q == LK_ADDR)
        begin
          st_d = sh_q[0] ? LK_RDATA : LK_CMD;
          oe_d = sh_q[0] && !rd_byte[7];
        end
        else if (st_q == LK_CMD)
          st_d = LK_WDATA;
      end
    end
    // R1: bounded conversion time
    if (conv_on_q)
    begin
      conv_cnt_d = conv_cnt_q + 1'b1;
      if (conv_cnt_q >= conv_limit - 1'b1)
      begin
        conv_fin = 1'b1;
        conv_cnt_d = '0;
        conv_on_d = cont_q;
        done_d = 1'b1;
        temp_d = conv_val;
        // R11: flags set, set wins
        if ($signed(conv_val) >= $signed(th_q & mask))
        begin
          thf_d = 1'b1;
          act_d = 1'b1;
        end
        if ($signed(conv_val) < $signed(tl_q & mask))
        begin
          tlf_d = 1'b1;
          act_d = 1'b0;
        end
      end
    end
    // R2: programming cycle commit
    if (ee_busy_q)
    begin
      ee_cnt_d = ee_cnt_q + 1'b1;
      if (ee_cnt_q == EE_CNT_W'(EE_WRITE_CYCLES - 1))
      begin
        ee_busy_d = 1'b0;
        unique case (ee_tgt_q)
          EE_UPPER: th_d = ee_data_q;
          EE_LOWER: tl_d = ee_data_q;
          default: nv_cfg_d = ee_data_q[1:0];
        endcase
      end
    end
  end
  // ==========================================================
  // Registers
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st_q <= LK_IDLE; bit_q <= 4'h0; sh_q <= 8'h00; cmd_q <= 8'h00; wbuf_q <= 8'h00;
      byte_q <= 1'b0; oe_q <= 1'b0; ee_tgt_q <= EE_UPPER; ee_data_q <= 16'h0000;
      // R3: power-up temperature
      temp_q <= TEMP_RESET;
      // R4: upper factory value
      th_q <= TH_FACTORY;
      // R5: lower factory value
      tl_q <= TL_FACTORY;
      // R7: config reset 100011
      nv_cfg_q <= CFG_NV_FACTORY; res_q <= RES_RESET; done_q <= 1'b1;
      thf_q <= 1'b0; tlf_q <= 1'b0; act_q <= 1'b0;
      conv_on_q <= 1'b0; cont_q <= 1'b0; conv_cnt_q <= '0;
      ee_busy_q <= 1'b0; ee_cnt_q <= '0;
    end
    else
    begin
      st_q <= st_d; bit_q <= bit_d; sh_q <= sh_d; cmd_q <= cmd_d; wbuf_q <= wbuf_d;
      byte_q <= byte_d; oe_q <= oe_d; ee_tgt_q <= ee_tgt_d; ee_data_q <= ee_data_d;
      temp_q <= temp_d; th_q <= th_d; tl_q <= tl_d;
      nv_cfg_q <= nv_cfg_d; res_q <= res_d; done_q <= done_d;
      thf_q <= thf_d; tlf_q <= tlf_d; act_q <= act_d;
      conv_on_q <= conv_on_d; cont_q <= cont_d; conv_cnt_q <= conv_cnt_d;
      ee_busy_q <= ee_busy_d; ee_cnt_q <= ee_cnt_d;
    end
  end
  assign sda_out = 1'b0;
  assign sda_oe = oe_q;
  assign tout = nv_cfg_q[CFG_POL] ? act_q : !act_q;
  // ==========================================================
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_conv_time_bound: assert property (conv_on_q && !$changed(res_q) // R1
    |-> conv_cnt_q < conv_limit)
    else $error("conversion overran its time");
  chk_ee_cycle_max: assert property (ee_busy_q |-> ee_cnt_q < EE_CNT_W'(EE_WRITE_MAX_CYC)) // R2
    else $error("nonvolatile write too long");
  chk_result_update: assert property (conv_fin |=> temp_q == $past(conv_val)) // R3
    else $error("result not latched");
  chk_upper_commit: assert property ($fell(ee_busy_q) && $past(ee_tgt_q) == EE_UPPER
    |-> th_q == $past(ee_data_q)) // R4
    else $error("upper trip point not stored");
  chk_lower_commit: assert property ($fell(ee_busy_q) && $past(ee_tgt_q) == EE_LOWER
    |-> tl_q == $past(ee_data_q)) // R5
    else $error("lower trip point not stored");
  chk_nv_cfg_change: assert property ($changed(nv_cfg_q) |-> $fell(ee_busy_q)) // R6
    else $error("nonvolatile config changed outside write cycle");
  chk_res_width: assert property (conv_fin && res_q == 2'h3 |=> temp_q[3:0] == 4'h0) // R8
    else $error("low result bits not zero");
  chk_low_bits_zero: assert property (cmd_q == CMD_READ_TEMP // R9
    |-> (rd_word & ~mask) == 16'h0000)
    else $error("unused result bits set");
  chk_flag_sticky: assert property ($fell(thf_q) || $fell(tlf_q) |-> $past(cfg_wr)) // R11
    else $error("flag cleared without write");
  chk_ee_no_restart: assert property (ee_busy_q && $past(ee_busy_q)
    |-> ee_data_q == $past(ee_data_q)) // R12
    else $error("write accepted during write cycle");
  cov_conv_done: cover property (conv_fin);
  cov_ee_commit: cover property ($fell(ee_busy_q));
  cov_high_flag: cover property ($rose(thf_q));
  cov_read_byte: cover property (st_q == LK_RDATA && bit_q == 4'h8);
endmodule

/* verification/tsr_host.sv */
// Two-wire bus host model for the register bank
`timescale 1ns/1ns
module tsr_host
(
  // Bus pins
  output logic scl,
  output logic sda_pull,
  input wire logic sda,
  // Read results
  output logic rd_valid,
  output logic [15:0] rd_data
);
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
    rd_valid = 1'b0;
    rd_data = 16'h0000;
  end
  // ==========================================================
  // Bit and frame level, SCL stands high between frames
  task automatic bit_w(input logic b);
    sda_pull = !b;
    #80 scl = 1'b1;
    #160 scl = 1'b0;
    #80;
  endtask
  task automatic bit_r(output logic b);
    sda_pull = 1'b0;
    #80 scl = 1'b1;
    #80 b = sda;
    #80 scl = 1'b0;
    #80;
  endtask
  task automatic start();
    sda_pull = 1'b0;
    #80 scl = 1'b1;
    #80 sda_pull = 1'b1;
    #80 scl = 1'b0;
    #80;
  endtask
  task automatic stop();
    sda_pull = 1'b1;
    #80 scl = 1'b1;
    #80 sda_pull = 1'b0;
    #160;
  endtask
  task automatic wbyte(input logic [7:0] d, inout logic ok);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_w(d[i]);
    bit_r(a);
    ok = ok & !a;
  endtask
  // ==========================================================
  // Register transfers
  task automatic wr(input logic [6:0] adr, input logic [7:0] cmd, input int n,
                    input logic [15:0] d, output logic ok);
    ok = 1'b1;
    start();
    wbyte({adr, 1'b0}, ok);
    wbyte(cmd, ok);
    for (int i = n - 1; i >= 0; i--)
      wbyte(d[i*8+:8], ok);
    stop();
  endtask
  task automatic rd(input logic [6:0] adr, input logic [7:0] cmd, input int n);
    logic ok;
    logic b;
    logic [15:0] v;
    ok = 1'b1;
    v = 16'h0000;
    start();
    wbyte({adr, 1'b0}, ok);
    wbyte(cmd, ok);
    start();
    wbyte({adr, 1'b1}, ok);
    for (int k = 0; k < n; k++)
    begin
      v = v << 8;
      for (int i = 7; i >= 0; i--)
      begin
        bit_r(b);
        v[i] = b;
      end
      bit_w(k == n - 1);
    end
    stop();
    rd_data = v;
    rd_valid = 1'b1;
    #40 rd_valid = 1'b0;
  endtask
endmodule

/* verification/tsr_regs_tb.sv */
// Self-checking bench for the thermometer user register bank
`timescale 1ns/1ns
module tsr_regs_tb;
  import tsr_pkg::*;
  localparam int CONV = 50;
  localparam int EEW = 20;
  logic clk, reset, sda_out, sda_oe, tout, scl, host_pull, rd_valid;
  logic [2:0] addr_pins;
  logic [6:0] adr;
  logic [15:0] sensor_temp, rd_data;
  logic [15:0] exp_q[$];
  wire sda = sda_oe ? sda_out : (host_pull ? 1'b0 : 1'b1);
  int n_fail = 0, comparisons = 0, cycles = 0, seed = 34;
  tsr_regs #(.CONV_9BIT_CYCLES(CONV), .EE_WRITE_CYCLES(EEW)) tsr_regs_inst (.clk(clk),
    .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_pins(addr_pins), .sensor_temp(sensor_temp), .tout(tout));
  tsr_host tsr_host_inst (.scl(scl), .sda_pull(host_pull), .sda(sda), .rd_valid(rd_valid),
    .rd_data(rd_data));
  always #20 clk = ~clk;
  // ==========================================================
  // Checking and reporting
  task automatic give_verdict();
    if (exp_q.size() != 0)
      n_fail++;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask
  always @(posedge rd_valid)
  begin
    if (exp_q.size() > 0)
      chk(rd_data, exp_q.pop_front());
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_fail++;
      give_verdict();
    end
  end
  // ==========================================================
  // Bus helpers
  task automatic waitc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rdx(input logic [7:0] cmd, input int n, input logic [15:0] e);
    exp_q.push_back(e);
    tsr_host_inst.rd(adr, cmd, n);
  endtask
  task automatic wrx(input logic [7:0] cmd, input int n, input logic [15:0] d);
    logic ok;
    tsr_host_inst.wr(adr, cmd, n, d, ok);
    chk({15'h0000, ok}, 16'h0001);
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    logic [15:0] up, t, m;
    logic hi, lo, act, ok;
    clk = 1'b0;
    reset = 1'b1;
    sensor_temp = 16'h0000;
    addr_pins = 3'($random(seed));
    adr = {BUS_ADDR_PREFIX, addr_pins};
    hi = 1'b0;
    lo = 1'b0;
    act = 1'b0;
    waitc(8);
    reset = 1'b0;
    waitc(4);
    rdx(CMD_READ_TEMP, 2, 16'hc400);
    rdx(CMD_ACCESS_UPPER, 2, 16'h0f00);
    rdx(CMD_ACCESS_LOWER, 2, 16'h0a00);
    rdx(CMD_ACCESS_CFG, 1, 16'h008c);
    tsr_host_inst.wr(adr ^ 7'h01, CMD_ACCESS_UPPER, 2, 16'h5555, ok);
    chk({15'h0000, ok}, 16'h0000);
    up = 16'($random(seed));
    wrx(CMD_ACCESS_UPPER, 2, up);
    waitc(EEW + 10);
    rdx(CMD_ACCESS_UPPER, 2, up & 16'hfff0);
    for (int r = 0; r < 4; r++)
    begin
      m = 16'hfff0 << (3 - r);
      wrx(CMD_ACCESS_CFG, 1, {8'h00, 3'b011, 1'b0, 2'(r), 2'b01});
      waitc(EEW + 10);
      sensor_temp = 16'($random(seed));
      t = sensor_temp & m;
      wrx(CMD_START_CONV, 0, 16'h0000);
      waitc((CONV << r) + 10);
      if ($signed(t) >= $signed(up & m))
      begin
        hi = 1'b1;
        act = 1'b1;
      end
      if ($signed(t) < $signed(TL_FACTORY & m))
      begin
        lo = 1'b1;
        act = 1'b0;
      end
      chk({15'h0000, tout}, {15'h0000, !act});
      rdx(CMD_READ_TEMP, 2, t);
      rdx(CMD_ACCESS_UPPER, 2, up & m);
    end
    rdx(CMD_ACCESS_CFG, 1, {8'h00, 1'b1, hi, lo, 5'b01101});
    wrx(CMD_ACCESS_CFG, 1, 16'h000d);
    waitc(EEW + 10);
    rdx(CMD_ACCESS_CFG, 1, 16'h008d);
    wrx(CMD_ACCESS_CFG, 1, 16'h0003);
    waitc(EEW + 10);
    rdx(CMD_ACCESS_CFG, 1, 16'h0083);
    rdx(CMD_READ_TEMP, 2, t & 16'hff80);
    chk({15'h0000, tout}, {15'h0000, act});
    wrx(CMD_STOP_CONV, 0, 16'h0000);
    waitc(4);
    give_verdict();
  end
endmodule
